// ==== core/pdcap_pkg.sv ====
package pdcap_pkg;

    localparam logic [31:0] PDCAP_DEVCAP_OFFSET = 32'h0000_0044;

    // Field positions
    localparam int PDCAP_MPS_LSB   = 0;
    localparam int PDCAP_PFS_LSB   = 3;
    localparam int PDCAP_EXTENDED_TAG_SUPPORTED_BIT  = 5;
    localparam int PDCAP_SHL_LSB   = 6;
    localparam int PDCAP_DPL_LSB   = 9;
    localparam int PDCAP_ABP_BIT   = 12;
    localparam int PDCAP_AIP_BIT   = 13;
    localparam int PDCAP_PIP_BIT   = 14;
    localparam int PDCAP_RBE_BIT   = 15;
    localparam int PDCAP_SPV_LSB   = 18;
    localparam int PDCAP_SPS_LSB   = 26;

    // Offset of the lock register, bit 0 locks the writable fields
    localparam logic [31:0] PDCAP_LOCK_OFFSET = 32'h0000_0048;

    // Reset values
    localparam logic [2:0] PDCAP_MPS_RESET  = 3'h1;
    localparam logic       PDCAP_EXTENDED_TAG_SUPPORTED_RESET = 1'b1;
    localparam logic [1:0] PDCAP_PFS_VALUE  = 2'h0;
    localparam logic [2:0] PDCAP_LAT_VALUE  = 3'h0;
    localparam logic       PDCAP_IND_VALUE  = 1'b0;
    localparam logic       PDCAP_RBE_VALUE  = 1'b1;
    localparam logic [7:0] PDCAP_SPV_RESET  = 8'h00;
    localparam logic [1:0] PDCAP_SPS_RESET  = 2'h0;

    // AHB codes
    localparam logic [1:0] PDCAP_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] PDCAP_HTRANS_SEQ    = 2'h3;

    typedef struct packed {
        logic       valid;
        logic [7:0] value;
        logic [1:0] scale;
    } pdcap_spl_msg_t;

    typedef enum logic {
        PDCAP_IDLE,
        PDCAP_DATA
    } pdcap_phase_t;

endpackage

// ==== core/pdcap_regs.sv ====
module pdcap_regs #(
    parameter bit IS_UPSTREAM = 1'b1
) (
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    input  wire logic                     clk_en,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    input  wire pdcap_pkg::pdcap_spl_msg_t spl_msg,
    output logic [31:0]                   hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   device_capabilities
);
    import pdcap_pkg::*;

    logic [2:0]   mps_reg;
    logic         extended_tag_supported_reg;
    logic         lock_reg;
    logic [7:0]   spv_reg;
    logic [1:0]   sps_reg;
    logic [31:0]  dcap_reg;
    logic [31:0]  rdata_reg;
    logic         wr_pend_reg;
    logic [31:0]  wr_addr_reg;
    pdcap_phase_t phase_reg;
    logic [31:0]  dcap_next;
    logic         addr_ok;
    logic         ready_reg;
    logic         resp_reg;

    assign addr_ok = hsel && hready && htrans[1];

    function automatic logic [31:0] pack_dcap(
        input logic [2:0] mps,
        input logic       extended_tag_supported,
        input logic [7:0] spv,
        input logic [1:0] sps
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        v[PDCAP_MPS_LSB +: 3] = mps;
        v[PDCAP_PFS_LSB +: 2] = PDCAP_PFS_VALUE;
        v[PDCAP_EXTENDED_TAG_SUPPORTED_BIT] = extended_tag_supported;
        v[PDCAP_SHL_LSB +: 3] = PDCAP_LAT_VALUE;
        v[PDCAP_DPL_LSB +: 3] = PDCAP_LAT_VALUE;
        v[PDCAP_ABP_BIT] = PDCAP_IND_VALUE;
        v[PDCAP_AIP_BIT] = PDCAP_IND_VALUE;
        v[PDCAP_PIP_BIT] = PDCAP_IND_VALUE;
        v[PDCAP_RBE_BIT] = PDCAP_RBE_VALUE;
        v[PDCAP_SPV_LSB +: 8] = spv;
        v[PDCAP_SPS_LSB +: 2] = sps;
        return v;
    endfunction

    // Data phase tracking; zero wait states
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            phase_reg   <= PDCAP_IDLE;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            if (hready)
            begin
                phase_reg   <= addr_ok ? PDCAP_DATA : PDCAP_IDLE;
                wr_pend_reg <= addr_ok && hwrite;
                wr_addr_reg <= haddr;
            end
        end
    end

    // Writable fields; lock freezes them
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            mps_reg  <= PDCAP_MPS_RESET;
            extended_tag_supported_reg <= PDCAP_EXTENDED_TAG_SUPPORTED_RESET;
            lock_reg <= 1'b0;
        end
        else if (clk_en && wr_pend_reg)
        begin
            if (wr_addr_reg[7:2] == PDCAP_DEVCAP_OFFSET[7:2] && !lock_reg)
            begin
                mps_reg  <= hwdata[PDCAP_MPS_LSB +: 3];
                extended_tag_supported_reg <= hwdata[PDCAP_EXTENDED_TAG_SUPPORTED_BIT];
            end
            if (wr_addr_reg[7:2] == PDCAP_LOCK_OFFSET[7:2])
            begin
                // Lock is one-way until reset
                lock_reg <= lock_reg | hwdata[0];
            end
        end
    end

    // Slot power capture; downstream ports never update
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            spv_reg <= PDCAP_SPV_RESET;
            sps_reg <= PDCAP_SPS_RESET;
        end
        else if (clk_en && IS_UPSTREAM && spl_msg.valid)
        begin
            spv_reg <= spl_msg.value;
            sps_reg <= spl_msg.scale;
        end
    end

    assign dcap_next = pack_dcap(mps_reg, extended_tag_supported_reg, spv_reg, sps_reg);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            dcap_reg <= pack_dcap(PDCAP_MPS_RESET, PDCAP_EXTENDED_TAG_SUPPORTED_RESET,
                                  PDCAP_SPV_RESET, PDCAP_SPS_RESET);
        end
        else if (clk_en)
        begin
            dcap_reg <= dcap_next;
        end
    end

    // Read data registered at address phase; unmapped reads zero
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (clk_en && addr_ok && !hwrite)
        begin
            if (haddr[7:2] == PDCAP_DEVCAP_OFFSET[7:2])
                rdata_reg <= dcap_next;
            else if (haddr[7:2] == PDCAP_LOCK_OFFSET[7:2])
                rdata_reg <= {31'h0000_0000, lock_reg};
            else
                rdata_reg <= 32'h0000_0000;
        end
    end

    // Bus answer from flops; never a wait state, never an error
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ready_reg <= 1'b1;
            resp_reg  <= 1'b0;
        end
        else if (clk_en)
        begin
            ready_reg <= 1'b1;
            resp_reg  <= 1'b0;
        end
    end

    assign hrdata              = rdata_reg;
    assign hreadyout           = ready_reg;
    assign hresp               = resp_reg;
    assign device_capabilities = dcap_reg;

    property p_fixed_zero;
        @(posedge sys_clk) disable iff (!resetn)
        (device_capabilities[17:3] & 15'h6ffb) == 15'h0000;
    endproperty
    a_fixed_zero: assert property (p_fixed_zero)
        else $error("fixed zero fields nonzero");

    property p_phantom;
        @(posedge sys_clk) disable iff (!resetn)
        device_capabilities[4:3] == 2'h0;
    endproperty
    a_phantom: assert property (p_phantom)
        else $error("phantom field nonzero");

    property p_shallow;
        @(posedge sys_clk) disable iff (!resetn)
        device_capabilities[8:6] == 3'h0;
    endproperty
    a_shallow: assert property (p_shallow)
        else $error("shallow latency field nonzero");

    property p_deep;
        @(posedge sys_clk) disable iff (!resetn)
        device_capabilities[11:9] == 3'h0;
    endproperty
    a_deep: assert property (p_deep)
        else $error("deep latency field nonzero");

    property p_ind;
        @(posedge sys_clk) disable iff (!resetn)
        device_capabilities[14:12] == 3'h0;
    endproperty
    a_ind: assert property (p_ind)
        else $error("indicator bits nonzero");

    property p_rbe;
        @(posedge sys_clk) disable iff (!resetn)
        device_capabilities[15] == 1'b1;
    endproperty
    a_rbe: assert property (p_rbe)
        else $error("role based error bit clear");

    property p_rsv;
        @(posedge sys_clk) disable iff (!resetn)
        device_capabilities[17:16] == 2'h0 &&
        device_capabilities[31:28] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bits nonzero");

    property p_capture_value;
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && IS_UPSTREAM && spl_msg.valid ##1 clk_en |=>
        device_capabilities[25:18] == $past(spl_msg.value, 2);
    endproperty
    a_capture_value: assert property (p_capture_value)
        else $error("slot power value not captured");

    property p_capture_scale;
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && IS_UPSTREAM && spl_msg.valid ##1 clk_en |=>
        device_capabilities[27:26] == $past(spl_msg.scale, 2);
    endproperty
    a_capture_scale: assert property (p_capture_scale)
        else $error("slot power scale not captured");

    property p_down_zero;
        @(posedge sys_clk) disable iff (!resetn)
        !IS_UPSTREAM |-> device_capabilities[27:18] == 10'h000;
    endproperty
    a_down_zero: assert property (p_down_zero)
        else $error("downstream slot power nonzero");

    property p_locked;
        @(posedge sys_clk) disable iff (!resetn)
        lock_reg && clk_en |=> $stable(mps_reg);
    endproperty
    a_locked: assert property (p_locked)
        else $error("locked payload field changed");

    property p_extended_tag_supported_locked;
        @(posedge sys_clk) disable iff (!resetn)
        lock_reg && clk_en |=> $stable(extended_tag_supported_reg);
    endproperty
    a_extended_tag_supported_locked: assert property (p_extended_tag_supported_locked)
        else $error("locked tag bit changed");

    property p_lock_sticky;
        @(posedge sys_clk) disable iff (!resetn)
        lock_reg |=> lock_reg;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock released without reset");

    property p_write_mps;
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && wr_pend_reg && !lock_reg &&
        wr_addr_reg[7:2] == PDCAP_DEVCAP_OFFSET[7:2] |=>
        mps_reg == $past(hwdata[PDCAP_MPS_LSB +: 3]);
    endproperty
    a_write_mps: assert property (p_write_mps)
        else $error("payload field write lost");

    property p_write_extended_tag_supported;
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && wr_pend_reg && !lock_reg &&
        wr_addr_reg[7:2] == PDCAP_DEVCAP_OFFSET[7:2] |=>
        extended_tag_supported_reg == $past(hwdata[PDCAP_EXTENDED_TAG_SUPPORTED_BIT]);
    endproperty
    a_write_extended_tag_supported: assert property (p_write_extended_tag_supported)
        else $error("tag bit write lost");

    property p_image;
        @(posedge sys_clk) disable iff (!resetn)
        clk_en |=> device_capabilities == $past(dcap_next);
    endproperty
    a_image: assert property (p_image)
        else $error("register image not refreshed");

    property p_read;
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && addr_ok && !hwrite &&
        haddr[7:2] == PDCAP_DEVCAP_OFFSET[7:2] |=>
        hrdata[15] && hrdata == $past(dcap_next);
    endproperty
    a_read: assert property (p_read)
        else $error("read of capabilities wrong");

    property p_read_lock;
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && addr_ok && !hwrite &&
        haddr[7:2] == PDCAP_LOCK_OFFSET[7:2] |=>
        hrdata == {31'h0000_0000, $past(lock_reg)};
    endproperty
    a_read_lock: assert property (p_read_lock)
        else $error("read of lock wrong");

    property p_read_unmapped;
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && addr_ok && !hwrite &&
        haddr[7:2] != PDCAP_DEVCAP_OFFSET[7:2] &&
        haddr[7:2] != PDCAP_LOCK_OFFSET[7:2] |=> hrdata == 32'h0000_0000;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("unmapped read nonzero");

    property p_okay;
        @(posedge sys_clk) disable iff (!resetn)
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus answer not ready and okay");

    c_read: cover property (@(posedge sys_clk) disable iff (!resetn)
        addr_ok && !hwrite);
    c_write: cover property (@(posedge sys_clk) disable iff (!resetn)
        wr_pend_reg && !lock_reg);
    c_msg: cover property (@(posedge sys_clk) disable iff (!resetn)
        spl_msg.valid && IS_UPSTREAM);
    c_lock: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(lock_reg));

endmodule

// ==== tb/pdcap_link_partner.sv ====
module pdcap_link_partner (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             go,
    input  wire logic [7:0]       v,
    input  wire logic [1:0]       s,
    output pdcap_pkg::pdcap_spl_msg_t spl_msg
);
    timeunit 1ns;
    timeprecision 1ps;
    import pdcap_pkg::*;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            spl_msg <= '0;
        else
        begin
            spl_msg.valid <= go;
            // Lines wander between messages, so a stale latch shows up
            spl_msg.value <= go ? v : ~spl_msg.value;
            spl_msg.scale <= go ? s : ~spl_msg.scale;
        end
    end
endmodule

// ==== tb/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pdcap_pkg::*;

    logic           sys_clk, resetn, clk_en, hsel, hwrite, go, extended_tag_supported;
    logic           hreadyout, hresp, rd_pend;
    logic [31:0]    haddr, hwdata, hrdata, dcap_up, dcap_dn, w;
    logic [1:0]     htrans, s;
    logic [2:0]     hsize, mps;
    logic [7:0]     v;
    pdcap_spl_msg_t spl_msg;
    logic [31:0]    exp_q[$];
    int             bad_count, checks, cyc;

    pdcap_regs #(.IS_UPSTREAM(1'b1)) pdcap_regs_inst (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .spl_msg(spl_msg),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .device_capabilities(dcap_up));
    // Downstream port shares the bus and the messages
    pdcap_regs #(.IS_UPSTREAM(1'b0)) pdcap_regs_dn_inst (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .spl_msg(spl_msg),
        .hrdata(), .hreadyout(), .hresp(), .device_capabilities(dcap_dn));
    pdcap_link_partner pdcap_link_partner_inst (.sys_clk(sys_clk),
        .resetn(resetn), .go(go), .v(v), .s(s), .spl_msg(spl_msg));

    function automatic logic [31:0] img(logic [2:0] m, logic t,
                                        logic [7:0] pv, logic [1:0] ps);
        return {4'h0, ps, pv, 2'h0, 1'b1, 9'h000, t, 2'h0, m};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, ex);
        checks++;
        if (seen !== ex)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= PDCAP_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(input logic [31:0] a, ex);
        exp_q.push_back(ex);
        xfer(a, 1'b0, $urandom);
    endtask

    task automatic send(input logic [7:0] pv, input logic [1:0] ps);
        go <= 1'b1;
        v <= pv;
        s <= ps;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Read data is taken at the edge closing the data phase
    always @(posedge sys_clk)
    begin
        cyc++;
        if (rd_pend)
            check("hrdata", hrdata, exp_q.pop_front());
        rd_pend = resetn && clk_en && hsel && htrans == PDCAP_HTRANS_NONSEQ
                  && !hwrite && hreadyout;
        if (cyc == 3000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    initial
    begin
        {resetn, clk_en, hsel, hwrite, go} = 5'h00;
        {haddr, hwdata, htrans, v, s} = '0;
        hsize = 3'h2;
        void'($urandom(32'hb14c));
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        clk_en <= 1'b1;
        check("dcap", dcap_up, img(3'h1, 1'b1, 8'h00, 2'h0));
        rd(PDCAP_DEVCAP_OFFSET, img(3'h1, 1'b1, 8'h00, 2'h0));
        for (int i = 0; i < 5; i++)
        begin
            w = (i == 0) ? 32'hffff_ffff : $urandom;
            xfer(PDCAP_DEVCAP_OFFSET, 1'b1, w);
            mps = w[2:0];
            extended_tag_supported = w[5];
            rd(PDCAP_DEVCAP_OFFSET, img(mps, extended_tag_supported, 8'h00, 2'h0));
        end
        for (int i = 0; i < 4; i++)
        begin
            w = $urandom;
            send(w[7:0], i[1:0]);
            check("dcap", dcap_up, img(mps, extended_tag_supported, w[7:0], i[1:0]));
            check("dcap_dn", dcap_dn, img(mps, extended_tag_supported, 8'h00, 2'h0));
            check("power_value", {24'h00_0000, dcap_up[25:18]},
                  {24'h00_0000, w[7:0]});
            rd(PDCAP_DEVCAP_OFFSET, img(mps, extended_tag_supported, w[7:0], i[1:0]));
        end
        // Frozen clock enable must drop the message
        clk_en <= 1'b0;
        send(~w[7:0], 2'h1);
        clk_en <= 1'b1;
        rd(PDCAP_DEVCAP_OFFSET, img(mps, extended_tag_supported, w[7:0], 2'h3));
        xfer(PDCAP_LOCK_OFFSET, 1'b1, 32'h0000_0001);
        rd(PDCAP_LOCK_OFFSET, 32'h0000_0001);
        xfer(PDCAP_DEVCAP_OFFSET, 1'b1, ~img(mps, extended_tag_supported, 8'h00, 2'h0));
        rd(PDCAP_DEVCAP_OFFSET, img(mps, extended_tag_supported, w[7:0], 2'h3));
        rd(32'h0000_004c, 32'h0000_0000);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(PDCAP_DEVCAP_OFFSET, img(3'h1, 1'b1, 8'h00, 2'h0));
        repeat (2) @(posedge sys_clk);
        give_verdict();
    end
endmodule
